// ===== design/arpt_pkg.sv
// arpt_pkg: constants and carrier types of the 12-bit autoreload pulse timer
// assumes: byte-wide register port, one 50 MHz clock, synchronous reset
package arpt_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ARPT_OFS_TCS = 8'h0d;
	localparam logic [7:0] ARPT_OFS_CNTH = 8'h0e;
	localparam logic [7:0] ARPT_OFS_CNTL = 8'h0f;
	localparam logic [7:0] ARPT_OFS_RLH = 8'h10;
	localparam logic [7:0] ARPT_OFS_RLL = 8'h11;
	localparam logic [7:0] ARPT_OFS_POC = 8'h12;
	localparam logic [7:0] ARPT_OFS_PCS = 8'h13;
	localparam logic [7:0] ARPT_OFS_DVH = 8'h17;
	localparam logic [7:0] ARPT_OFS_DVL = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ARPT_TCS_COMPARE_IRQ_ENABLE = 0;
	localparam int ARPT_TCS_WRAP_IRQ_ENABLE = 1;
	localparam int ARPT_TCS_WRAP = 2;
	localparam int ARPT_TCS_SEL_LO = 3;
	localparam int ARPT_PCS_CMPF = 0;
	localparam int ARPT_PCS_INV = 1;
	localparam int ARPT_POC_OE = 0;

	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [11:0] ARPT_CNT_RST = 12'h000;
	localparam logic [11:0] ARPT_CNT_TOP = 12'hfff;
	localparam logic [11:0] ARPT_DUTY_OFF = 12'h000;
	localparam logic [7:0] ARPT_BYTE_RST = 8'h00;
	localparam int ARPT_PERIOD_BASE = 4096;
	localparam int ARPT_SLOW_DIV = 32;
	localparam logic [4:0] ARPT_SLOW_LAST = 5'(ARPT_SLOW_DIV - 1);

	// ----------------------------------------
	// counter clock select codes
	// ----------------------------------------
	localparam logic [1:0] ARPT_SEL_OFF = 2'h0;
	localparam logic [1:0] ARPT_SEL_TICK = 2'h1;
	localparam logic [1:0] ARPT_SEL_CPU = 2'h2;
	localparam logic [1:0] ARPT_SEL_RSVD = 2'h3;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} arpt_bus_t;

	typedef struct packed {
		logic slow;
		logic wait_mode;
		logic active_halt;
		logic full_halt;
	} arpt_power_t;

endpackage

// ===== design/arpt_timer.sv
// arpt_timer: 12-bit autoreload timer with one pulse output and compare
// assumes: inputs synchronous to clk, tick is a one-cycle pulse, strobes one cycle
//
// Function
// RULE1 - pulse period is counter clock divided by 4096 minus reload value
// RULE2 - overflow reloads counter, moves duty into active copy, pulse goes high
// RULE3 - counter equal to active duty drives pulse low
// RULE4 - invert setting flips the pulse before the pin
// RULE5 - output enable drives pin push-pull, else pin released
// RULE6 - high duty byte write locks compare until low byte written
// RULE7 - software writes high duty byte before low byte
// RULE8 - compare mode uses written duty value at once
// RULE9 - compare mode match sets compare flag, interrupt if enabled
// RULE10 - compare inactive while duty value is zero
// RULE11 - overflow copies duty into shadow; pulse mode compares shadow
// RULE12 - software keeps reload at most 4094
// RULE13 - slow mode divides input by 32, wait no effect, halt stops
// RULE14 - active halt stops timer unless tick selected and wrap irq enabled
// RULE15 - wrap wakes from wait and tick active halt; compare from wait only
// RULE16 - clock select: off, tick, cpu clock, reserved; reset clears it
// RULE17 - wrap flag set on fff to reload; status read clears it
// RULE18 - wrap flag stays visible one more counter clock after clear
// RULE19 - wrap and compare irq enables gate the two requests
// RULE20 - counter resets to zero and counts while a clock is selected and no halt stops it
// RULE21 - software reads counter low byte first, unlatched
// RULE22 - software keeps upper three status bits zero
// RULE23 - compare flag set on match, cleared by pulse status read
// RULE24 - byte-wide registers, single-cycle reads and writes
`timescale 1ns/10ps

module arpt_timer
	import arpt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire arpt_bus_t bus_i,
	output logic [7:0] rdata_o,
	// timebase and power modes
	input wire logic lite_timebase_tick_i,
	input wire arpt_power_t power_i,
	// pulse pin
	output logic pulse_output_o,
	output logic pulse_output_oe_o,
	// requests
	output logic wrap_irq_o,
	output logic cmp_irq_o,
	output logic wake_o
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [1:0] sel_q;
	logic wrap_irq_enable_q;
	logic compare_irq_enable_q;
	logic wrap_flag_q;
	logic wrap_clr_pend_q;
	logic compare_match_flag_q;
	logic output_invert_q;
	logic pulse_output_enable_q;
	logic [11:0] reload_value_q;
	logic [11:0] duty_value_q;
	logic [11:0] shadow_q;
	logic cmp_lock_q;
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic [4:0] slow_cnt_q;
	logic pulse_q;
	logic pin_q;
	logic [7:0] rdata_q;

	logic wr_tcs, wr_rlh, wr_rll, wr_poc, wr_pcs, wr_dvh, wr_dvl;
	logic rd_tcs, rd_pcs;
	logic run, cpu_en, cnt_en, ovf_ev, cmp_hit;
	logic [11:0] cmp_val;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		wr_tcs = bus_i.wr && bus_i.addr == ARPT_OFS_TCS; // RULE24
		wr_rlh = bus_i.wr && bus_i.addr == ARPT_OFS_RLH;
		wr_rll = bus_i.wr && bus_i.addr == ARPT_OFS_RLL;
		wr_poc = bus_i.wr && bus_i.addr == ARPT_OFS_POC;
		wr_pcs = bus_i.wr && bus_i.addr == ARPT_OFS_PCS;
		wr_dvh = bus_i.wr && bus_i.addr == ARPT_OFS_DVH;
		wr_dvl = bus_i.wr && bus_i.addr == ARPT_OFS_DVL;
		rd_tcs = bus_i.rd && bus_i.addr == ARPT_OFS_TCS;
		rd_pcs = bus_i.rd && bus_i.addr == ARPT_OFS_PCS;
	end

	// ----------------------------------------
	// counter clock enable
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst || !power_i.slow) begin
			slow_cnt_q <= 5'h00;
		end else begin
			slow_cnt_q <= slow_cnt_q + 5'h01; // RULE13
		end
	end

	always_comb begin
		cpu_en = !power_i.slow || slow_cnt_q == ARPT_SLOW_LAST; // RULE13
		run = !power_i.full_halt // RULE13
			&& (!power_i.active_halt
			|| (sel_q == ARPT_SEL_TICK && wrap_irq_enable_q)); // RULE14
		unique case (sel_q) // RULE16
			ARPT_SEL_TICK: cnt_en = run && lite_timebase_tick_i;
			ARPT_SEL_CPU: cnt_en = run && cpu_en;
			ARPT_SEL_OFF, ARPT_SEL_RSVD: cnt_en = 1'b0;
		endcase
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_comb begin
		ovf_ev = cnt_en && cnt_q == ARPT_CNT_TOP;
		cnt_d = cnt_q;
		if (ovf_ev) begin
			cnt_d = reload_value_q; // RULE1 RULE2
		end else if (cnt_en) begin
			cnt_d = cnt_q + 12'h001; // RULE20
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= ARPT_CNT_RST; // RULE20
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_q <= ARPT_SEL_OFF; // RULE16
			wrap_irq_enable_q <= 1'b0; // RULE19
			compare_irq_enable_q <= 1'b0;
		end else if (wr_tcs) begin
			sel_q <= bus_i.wdata[ARPT_TCS_SEL_LO +: 2];
			wrap_irq_enable_q <= bus_i.wdata[ARPT_TCS_WRAP_IRQ_ENABLE];
			compare_irq_enable_q <= bus_i.wdata[ARPT_TCS_COMPARE_IRQ_ENABLE];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reload_value_q <= ARPT_CNT_RST;
		end else if (wr_rlh) begin
			reload_value_q[11:8] <= bus_i.wdata[3:0];
		end else if (wr_rll) begin
			reload_value_q[7:0] <= bus_i.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pulse_output_enable_q <= 1'b0;
			output_invert_q <= 1'b0;
		end else begin
			if (wr_poc) begin
				pulse_output_enable_q <= bus_i.wdata[ARPT_POC_OE];
			end
			if (wr_pcs) begin
				output_invert_q <= bus_i.wdata[ARPT_PCS_INV];
			end
		end
	end

	// ----------------------------------------
	// duty value, lock and shadow
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			duty_value_q <= ARPT_DUTY_OFF;
			cmp_lock_q <= 1'b0;
		end else if (wr_dvh) begin
			duty_value_q[11:8] <= bus_i.wdata[3:0];
			cmp_lock_q <= 1'b1; // RULE6
		end else if (wr_dvl) begin
			duty_value_q[7:0] <= bus_i.wdata;
			cmp_lock_q <= 1'b0; // RULE6
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shadow_q <= ARPT_DUTY_OFF;
		end else if (ovf_ev) begin
			shadow_q <= duty_value_q; // RULE2 RULE11
		end
	end

	// ----------------------------------------
	// compare
	// ----------------------------------------
	always_comb begin
		// compare mode sees the written value at once
		cmp_val = pulse_output_enable_q ? shadow_q : duty_value_q; // RULE8 RULE11
		cmp_hit = cnt_en && !cmp_lock_q // RULE6
			&& cmp_val != ARPT_DUTY_OFF // RULE10
			&& cnt_d == cmp_val; // RULE3 RULE9
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compare_match_flag_q <= 1'b0;
		end else if (cmp_hit) begin
			compare_match_flag_q <= 1'b1; // RULE9 RULE23
		end else if (rd_pcs) begin
			compare_match_flag_q <= 1'b0; // RULE23
		end
	end

	// ----------------------------------------
	// wrap flag with one counter clock of lag
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrap_flag_q <= 1'b0;
			wrap_clr_pend_q <= 1'b0;
		end else begin
			if (ovf_ev) begin
				wrap_flag_q <= 1'b1; // RULE17
				wrap_clr_pend_q <= 1'b0;
			end else if (rd_tcs && wrap_flag_q) begin
				wrap_clr_pend_q <= 1'b1; // RULE17
			end else if (wrap_clr_pend_q && cnt_en) begin
				wrap_flag_q <= 1'b0; // RULE18
				wrap_clr_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// pulse generator and pin
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pulse_q <= 1'b0;
		end else if (!pulse_output_enable_q) begin
			pulse_q <= 1'b0; // no pulse in compare mode
		end else if (cmp_hit) begin
			pulse_q <= 1'b0; // RULE3
		end else if (ovf_ev) begin
			pulse_q <= 1'b1; // RULE2
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pulse_q ^ output_invert_q; // RULE4
		end
	end

	assign pulse_output_o = pin_q;
	assign pulse_output_oe_o = pulse_output_enable_q; // RULE5

	// ----------------------------------------
	// requests and wake
	// ----------------------------------------
	assign wrap_irq_o = wrap_flag_q && wrap_irq_enable_q; // RULE19
	assign cmp_irq_o = compare_match_flag_q && compare_irq_enable_q; // RULE9 RULE19
	assign wake_o = !power_i.full_halt // RULE15
		&& ((power_i.wait_mode && (wrap_irq_o || cmp_irq_o))
		|| (power_i.active_halt && sel_q == ARPT_SEL_TICK && wrap_irq_o));

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= ARPT_BYTE_RST;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr) // RULE24
				ARPT_OFS_TCS: rdata_q <= {3'h0, sel_q, wrap_flag_q,
					wrap_irq_enable_q, compare_irq_enable_q};
				ARPT_OFS_CNTH: rdata_q <= {4'h0, cnt_q[11:8]}; // RULE21
				ARPT_OFS_CNTL: rdata_q <= cnt_q[7:0];
				ARPT_OFS_RLH: rdata_q <= {4'h0, reload_value_q[11:8]};
				ARPT_OFS_RLL: rdata_q <= reload_value_q[7:0];
				ARPT_OFS_POC: rdata_q <= {7'h00, pulse_output_enable_q};
				ARPT_OFS_PCS: rdata_q <= {6'h00, output_invert_q, compare_match_flag_q};
				ARPT_OFS_DVH: rdata_q <= {4'h0, duty_value_q[11:8]};
				ARPT_OFS_DVL: rdata_q <= duty_value_q[7:0];
				default: rdata_q <= ARPT_BYTE_RST;
			endcase
		end else begin
			rdata_q <= ARPT_BYTE_RST;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_wrap_step;
		cnt_en && cnt_q == ARPT_CNT_TOP;
	endsequence

	sequence s_clear_request;
		rd_tcs && wrap_flag_q && !ovf_ev ##1 !cnt_en;
	endsequence

	a_ovf_reload_cnt: assert property (s_wrap_step |=> cnt_q == $past(reload_value_q)) // RULE2
		else $error("counter not reloaded on overflow");

	a_ovf_sets_wrap: assert property (s_wrap_step |=> wrap_flag_q) // RULE17
		else $error("wrap flag not set on overflow");

	a_ovf_shadow_copy: assert property (s_wrap_step |=> shadow_q == $past(duty_value_q)) // RULE11
		else $error("shadow not loaded on overflow");

	a_cnt_step_up: assert property (cnt_en && cnt_q != ARPT_CNT_TOP
		|=> cnt_q == $past(cnt_q) + 12'h001) // RULE20
		else $error("counter did not increment");

	a_off_no_count: assert property (sel_q == ARPT_SEL_OFF || power_i.full_halt
		|=> $stable(cnt_q)) // RULE13
		else $error("counter moved while off or halted");

	a_ahalt_gate: assert property (power_i.active_halt && !wrap_irq_enable_q |-> !cnt_en) // RULE14
		else $error("counter enabled in active halt");

	a_slow_divide: assert property (power_i.slow && sel_q == ARPT_SEL_CPU && cnt_en
		|=> !(cnt_en && power_i.slow && sel_q == ARPT_SEL_CPU) [*8]) // RULE13
		else $error("slow mode enables too close together");

	a_wrap_lingers: assert property (s_clear_request |-> wrap_flag_q) // RULE18
		else $error("wrap flag cleared before next counter clock");

	a_lock_blocks: assert property (wr_dvh ##1 !wr_dvl [*2] |-> !cmp_hit) // RULE6
		else $error("compare fired while locked");

	a_zero_no_cmp: assert property (cmp_val == ARPT_DUTY_OFF
		|=> !$rose(compare_match_flag_q)) // RULE10
		else $error("compare fired on zero duty");

	a_cmp_sets_flag: assert property (cmp_hit |=> compare_match_flag_q) // RULE9
		else $error("compare flag not set on match");

	a_pin_polarity: assert property (pulse_output_enable_q |-> ##1
		pulse_output_o == ($past(pulse_q) ^ $past(output_invert_q))) // RULE4
		else $error("pin polarity wrong");

	a_pulse_high_ovf: assert property (pulse_output_enable_q && ovf_ev && !cmp_hit
		|=> pulse_q) // RULE2
		else $error("pulse not high after overflow");

	a_halt_no_wake: assert property (power_i.full_halt |-> !wake_o) // RULE15
		else $error("wake in full halt");

endmodule

// ===== verif/arpt_load.sv
// arpt_load: far-side load on the pulse pin, measures period and high time
// assumes: pin sampled on clk, no pull resistor on the pin
`timescale 1ns/10ps

module arpt_load (
	// clock
	input wire logic clk,
	// pin from the timer
	input wire logic pin_val,
	input wire logic pin_oe,
	// measurements
	output logic pin,
	output logic [15:0] period,
	output logic [15:0] high
);
	logic prev = 1'b0;
	logic [15:0] cnt = 16'h0000;
	logic [15:0] hcnt = 16'h0000;

	// released pin floats: show the opposite level
	assign pin = pin_oe ? pin_val : ~pin_val;
	always_ff @(posedge clk) begin
		prev <= pin;
		if (pin && !prev) begin
			period <= cnt;
			high <= hcnt;
			cnt <= 16'h0001;
			hcnt <= 16'h0001;
		end else begin
			cnt <= cnt + 16'h0001;
			hcnt <= hcnt + {15'h0000, pin};
		end
	end
endmodule

// ===== verif/arpt_timer_test.sv
// arpt_timer_test: self-checking bench for the autoreload pulse timer
// assumes: arpt_pkg compiled first, 50 MHz clock, load model on the pin
`timescale 1ns/10ps

module arpt_timer_test
	import arpt_pkg::*;
;
	logic clk;
	logic sys_rst = 1'b1;
	logic tk = 1'b0;
	arpt_bus_t bus = '0;
	arpt_power_t pwr = '0;
	logic [7:0] rdata;
	logic pout, poe, wirq, cirq, wake, pin;
	logic [15:0] period, high;
	logic [7:0] a, b;
	int fail_count = 0;
	int compares = 0;

	arpt_timer i_arpt_timer (.clk(clk), .sys_rst(sys_rst), .bus_i(bus), .rdata_o(rdata),
		.lite_timebase_tick_i(tk), .power_i(pwr), .pulse_output_o(pout),
		.pulse_output_oe_o(poe), .wrap_irq_o(wirq), .cmp_irq_o(cirq), .wake_o(wake));
	arpt_load i_arpt_load (.clk(clk), .pin_val(pout), .pin_oe(poe), .pin(pin),
		.period(period), .high(high));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] v);
		bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		v = rdata;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
		logic [7:0] v;
		rd(ad, v);
		check(v, exp);
	endtask
	task automatic duty(input logic [11:0] d);
		wr(8'h17, {4'h0, d[11:8]});
		wr(8'h18, d[7:0]);
	endtask
	task automatic tick;
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic gap(input int n, input logic [7:0] exp);
		rd(8'h0f, a);
		repeat (n) @(posedge clk);
		rd(8'h0f, b);
		check(8'(b - a), exp);
	endtask
	task automatic wait_hi(input bit w);
		for (int i = 0; i < 5000; i++) begin
			@(posedge clk);
			#1;
			if ((w ? cirq : wirq) === 1'b1) break;
		end
	endtask
	task automatic rst;
		sys_rst <= 1'b1;
		pwr <= '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [7:0] ra[7] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h12, 8'h13, 8'h33};
		rst();
		foreach (ra[i]) rdc(ra[i], 8'h00);
		wr(8'h10, 8'hff);
		wr(8'h0e, 8'h55);
		wr(8'h33, 8'haa);
		rdc(8'h10, 8'h0f);
		rdc(8'h0e, 8'h00);
		rdc(8'h33, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h0d, 8'h11);
		repeat (4200) @(posedge clk);
		#1;
		check(cirq, 1'b0);
	endtask
	task automatic t_count;
		rst();
		wr(8'h0d, 8'h08);
		repeat (5) tick();
		rdc(8'h0f, 8'h05);
		rdc(8'h0e, 8'h00);
		wr(8'h0d, 8'h00);
		repeat (3) tick();
		rdc(8'h0f, 8'h05);
		wr(8'h0d, 8'h18);
		gap(0, 8'h00);
		wr(8'h0d, 8'h10);
		gap(0, 8'h02);
		pwr <= '{slow: 1'b1, default: 1'b0};
		gap(62, 8'h02);
		pwr <= '{wait_mode: 1'b1, default: 1'b0};
		gap(0, 8'h02);
		pwr <= '{active_halt: 1'b1, default: 1'b0};
		gap(0, 8'h00);
		pwr <= '{full_halt: 1'b1, default: 1'b0};
		gap(0, 8'h00);
	endtask
	task automatic t_pwm;
		rst();
		wr(8'h10, 8'h0f);
		wr(8'h11, 8'hf0);
		duty(12'hff4);
		wr(8'h12, 8'h01);
		wr(8'h0d, 8'h10);
		repeat (4200) @(posedge clk);
		#1;
		check(period, 16'd16);
		check(high, 16'd4);
		check(poe, 1'b1);
		wr(8'h13, 8'h02);
		repeat (40) @(posedge clk);
		#1;
		check(high, 16'd12);
		duty(12'hff9);
		repeat (40) @(posedge clk);
		#1;
		check(high, 16'd7);
		rdc(8'h0e, 8'h0f);
		rdc(8'h0d, 8'h14);
		wr(8'h12, 8'h00);
		#1;
		check(poe, 1'b0);
	endtask
	task automatic t_cmp;
		rst();
		duty(12'h040);
		wr(8'h0d, 8'h11);
		wait_hi(1'b1);
		check(cirq, 1'b1);
		pwr <= '{wait_mode: 1'b1, default: 1'b0};
		#1;
		check(wake, 1'b1);
		pwr <= '{wait_mode: 1'b1, full_halt: 1'b1, default: 1'b0};
		#1;
		check(wake, 1'b0);
		pwr <= '0;
		wr(8'h0d, 8'h10);
		check(cirq, 1'b0);
		rdc(8'h13, 8'h01);
		rdc(8'h13, 8'h00);
		wr(8'h0d, 8'h11);
		wr(8'h17, 8'h00);
		repeat (4300) @(posedge clk);
		#1;
		check(cirq, 1'b0);
		wr(8'h18, 8'h40);
		wait_hi(1'b1);
		check(cirq, 1'b1);
	endtask
	task automatic t_wrap;
		rst();
		wr(8'h10, 8'h0f);
		wr(8'h11, 8'hfe);
		wr(8'h0d, 8'h0a);
		for (int i = 0; i < 5000 && wirq !== 1'b1; i++) tick();
		check(wirq, 1'b1);
		pwr <= '{active_halt: 1'b1, default: 1'b0};
		#1;
		check(wake, 1'b1);
		rdc(8'h0d, 8'h0e);
		rdc(8'h0d, 8'h0e);
		tick();
		rdc(8'h0d, 8'h0a);
		rdc(8'h0f, 8'hff);
	endtask

	task automatic finish_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_count();
		t_pwm();
		t_cmp();
		t_wrap();
		finish_test();
	end
endmodule
